// ### sac_cfg.svh
// sac_cfg.svh: register map, field positions, reset values and counts
// How it works
// (R1) Mode select low picks the parallel control path, high picks the serial addressable path.
// (R2) In parallel mode with the latch strobe held high, any change of the parallel weight bits is applied at once.
// (R3) After reset the attenuation word is all ones (maximum) in both modes unless the power-up preset is used.
// (R4) As the alternative, the word present on the parallel weight bits while coming out of reset is taken.
// (R5) The host keeps the latch strobe low throughout power-up so the preset is caught cleanly.
// (R6) Three strap inputs form the three-bit bus address, so eight devices can share one serial bus.
// (R7) A serial frame carries an address byte and is acted on only when it matches the strapped address.
// (R8) In serial and latched parallel modes the pending word moves to the attenuator on the strobe's leading edge.
// (R9) Bit 0 weighs a quarter dB, each higher bit doubles up to bit 6, and bit 7 of the data byte is ignored.
// (R10) Only the three low bits of the address byte are compared; the upper five are ignored.
// (R11) In serial mode one data bit is shifted in on every rising serial clock edge; the host changes data while it is low.
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_ATTEN 12'h004
`define SAC_OFF_STATUS 12'h008
`define SAC_OFF_FRAME 12'h00C

`define SAC_CTRL_FREEZE 0
`define SAC_CTRL_RST 1'h0

`define SAC_ST_SERIAL 8
`define SAC_ST_STRAP_LO 9
`define SAC_ST_RUN 12
`define SAC_ST_HIT 13

`define SAC_ATTEN_MAX 7'h7F
`define SAC_ATTEN_W 7
`define SAC_FRAME_W 16

`define SAC_FRAME_LAST 4'hF

`endif

// ### sac_pkg.sv
// sac_pkg.sv: types shared by the step attenuator control logic
package sac_pkg;

	// serial frame: address byte shifted first, data byte last
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sac_frame_t;

	// control pins after synchronisation
	typedef struct packed {
		logic serial;
		logic [2:0] strap;
		logic le;
		logic preset;
		logic [6:0] par;
	} sac_pins_t;

	typedef enum logic [1:0] {
		SAC_WAIT0 = 2'b00,
		SAC_WAIT1 = 2'b01,
		SAC_LOAD = 2'b10,
		SAC_RUN = 2'b11
	} sac_init_t;

endpackage

// ### sac_top.sv
// sac_top.sv: step attenuator control with serial, parallel and APB paths
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_top #(
	parameter int ATTEN_W = `SAC_ATTEN_W,
	parameter int FRAME_W = `SAC_FRAME_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial link, runs on its own clock
	input wire logic serial_clk,
	input wire logic serial_data,
	// control pins from the host
	input wire logic mode_select_pin,
	input wire logic latch_strobe,
	input wire logic pwrup_preset_pin,
	input wire logic strap_addr_bit0,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit2,
	input wire logic weight_bit_16db,
	input wire logic weight_bit_8db,
	input wire logic weight_bit_4db,
	input wire logic weight_bit_2db,
	input wire logic weight_bit_1db,
	input wire logic weight_bit_half_db,
	input wire logic weight_bit_quarter_db,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// attenuator stage drive
	output logic [6:0] atten_word
);

	if (ATTEN_W != 7 || FRAME_W != 16) begin : g_bad_param
		$error("sac_top serves a 7-bit word and 16-bit frame only");
	end

	function automatic logic addr_hit(input logic [7:0] a,
		input logic [2:0] s);
		addr_hit = (a[2:0] == s); // R10
	endfunction

	// link domain: reset brought over, shift register, bit count
	// limitation: the link leaves reset only after two more link
	// edges, so the host must clock twice once rst has fallen
	logic lrst_s1_q;
	logic lrst_s2_q;
	logic [15:0] shreg_q;
	logic [15:0] shreg_d;
	logic [3:0] bitcnt_q;
	logic [15:0] held_q;
	logic frame_tgl_q;
	logic frame_end;

	assign shreg_d = {shreg_q[14:0], serial_data}; // R11
	assign frame_end = (bitcnt_q == `SAC_FRAME_LAST);

	always_ff @(posedge serial_clk) begin
		lrst_s1_q <= rst;
		lrst_s2_q <= lrst_s1_q;
	end

	// a toggle per bit would alias against the slower ref_clk, so
	// only whole frames cross; the held word stays until the next
	always_ff @(posedge serial_clk) begin
		if (lrst_s2_q) begin
			shreg_q <= 16'h0000;
			bitcnt_q <= 4'h0;
			held_q <= 16'h0000;
			frame_tgl_q <= 1'b0;
		end else begin
			shreg_q <= shreg_d;
			bitcnt_q <= bitcnt_q + 4'h1;
			if (frame_end) begin
				held_q <= shreg_d;
				frame_tgl_q <= ~frame_tgl_q;
			end
		end
	end

	// pin synchronisers on ref_clk
	logic [12:0] pin_raw;
	logic [12:0] pin_s1_q;
	logic [12:0] pin_s2_q;
	logic le_s3_q;
	sac_pkg::sac_pins_t pins;

	assign pin_raw = {mode_select_pin,
		strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, // R6
		latch_strobe, pwrup_preset_pin,
		weight_bit_16db, weight_bit_8db, weight_bit_4db,
		weight_bit_2db, weight_bit_1db, weight_bit_half_db,
		weight_bit_quarter_db};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_s1_q <= 13'h0000;
			pin_s2_q <= 13'h0000;
			le_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			le_s3_q <= pins.le;
		end
	end

	assign pins = sac_pkg::sac_pins_t'(pin_s2_q);

	// frame ends cross as a toggle; frames closer than about three
	// ref_clk cycles would overwrite the held word before it is taken
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic take_frame;
	sac_pkg::sac_frame_t frame_q;

	assign take_frame = tgl_s2_q ^ tgl_s3_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= frame_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			frame_q <= 16'h0000;
		else if (take_frame)
			frame_q <= held_q;
	end

	// power-up sequence: wait out the synchroniser, then preset
	sac_pkg::sac_init_t init_q;
	sac_pkg::sac_init_t init_d;

	always_comb begin
		case (init_q)
			sac_pkg::SAC_WAIT0: init_d = sac_pkg::SAC_WAIT1;
			sac_pkg::SAC_WAIT1: init_d = sac_pkg::SAC_LOAD;
			sac_pkg::SAC_LOAD: init_d = sac_pkg::SAC_RUN;
			sac_pkg::SAC_RUN: init_d = sac_pkg::SAC_RUN;
			default: init_d = sac_pkg::SAC_WAIT0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			init_q <= sac_pkg::SAC_WAIT0;
		else
			init_q <= init_d;
	end

	// apb decode
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_atten;
	logic hit_status;
	logic hit_frame;
	logic mapped;
	logic wr_ctrl;
	logic wr_atten;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit_ctrl = (paddr == `SAC_OFF_CTRL);
	assign hit_atten = (paddr == `SAC_OFF_ATTEN);
	assign hit_status = (paddr == `SAC_OFF_STATUS);
	assign hit_frame = (paddr == `SAC_OFF_FRAME);
	assign mapped = hit_ctrl | hit_atten | hit_status | hit_frame;
	assign wr_ctrl = access & pwrite & hit_ctrl;
	assign wr_atten = access & pwrite & hit_atten;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// attenuation update paths
	logic le_rise;
	logic running;
	logic frame_hit;
	logic ser_upd;
	logic par_upd;
	logic preset_upd;
	logic freeze_q;
	logic [6:0] soft_q;
	logic [6:0] atten_q;
	logic [6:0] atten_d;

	assign le_rise = pins.le & ~le_s3_q;
	assign running = (init_q == sac_pkg::SAC_RUN);
	assign frame_hit = addr_hit(frame_q.addr, pins.strap); // R7
	assign ser_upd = running & ~freeze_q & pins.serial // R1
		& le_rise & frame_hit; // R8
	// strobe high makes the parallel word transparent: its rise
	// latches, and holding it high follows every bit change
	assign par_upd = running & ~freeze_q & ~pins.serial // R1
		& pins.le; // R2
	// preset only taken while the strobe reads low
	assign preset_upd = (init_q == sac_pkg::SAC_LOAD)
		& pins.preset & ~pins.le; // R4 R5

	always_comb begin
		if (wr_atten)
			atten_d = pwdata[6:0];
		else if (preset_upd)
			atten_d = pins.par; // R4
		else if (ser_upd)
			atten_d = frame_q.data[6:0]; // R9
		else if (par_upd)
			atten_d = pins.par; // R2
		else
			atten_d = atten_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			atten_q <= `SAC_ATTEN_MAX; // R3
		else
			atten_q <= atten_d;
	end

	assign atten_word = atten_q;

	// software registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			freeze_q <= `SAC_CTRL_RST;
			soft_q <= `SAC_ATTEN_MAX;
		end else begin
			if (wr_ctrl)
				freeze_q <= pwdata[`SAC_CTRL_FREEZE];
			if (wr_atten)
				soft_q <= pwdata[6:0];
		end
	end

	// read mux, snapshotted in the setup cycle
	logic [31:0] st_word;
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;

	assign st_word = {18'h00000, frame_hit, running, pins.strap,
		pins.serial, 1'b0, atten_q};
	assign rd_mux = hit_ctrl ? {31'h00000000, freeze_q} :
		hit_atten ? {25'h0000000, soft_q} :
		hit_status ? st_word :
		hit_frame ? {16'h0000, frame_q} : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (rst)
			prdata_q <= 32'h00000000;
		else if (setup)
			prdata_q <= rd_mux;
	end

	assign prdata = prdata_q;

endmodule

// ### sac_props.sv
// sac_props.sv: port checker for sac_top
`timescale 1ns/1ps
module sac_props (
	// clock and pins
	input wire logic ref_clk, rst, mode_select_pin, latch_strobe,
	input wire logic strap_addr_bit0, strap_addr_bit1, strap_addr_bit2,
	input wire logic weight_bit_16db, weight_bit_8db, weight_bit_4db,
	input wire logic weight_bit_2db, weight_bit_1db, weight_bit_half_db,
	input wire logic weight_bit_quarter_db,
	// apb and output
	input wire logic [11:0] paddr,
	input wire logic psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	input wire logic [6:0] atten_word
);
	wire [6:0] w = {weight_bit_16db, weight_bit_8db, weight_bit_4db,
		weight_bit_2db, weight_bit_1db, weight_bit_half_db,
		weight_bit_quarter_db};
	wire acc = psel && penable;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_max; $fell(rst) |-> atten_word == 7'h7F; endproperty
	a_max: assert property (p_max) else $error("word after reset");
	// apb writes excluded: they load the word from any mode
	property p_dir;
		(!mode_select_pin && latch_strobe && !psel && $stable(w))[*6]
		|-> atten_word == w;
	endproperty
	a_dir: assert property (p_dir) else $error("direct word");
	property p_low; (!latch_strobe && !psel)[*8] |=> $stable(atten_word);
	endproperty
	a_low: assert property (p_low) else $error("word moved");
	property p_ser;
		(mode_select_pin && latch_strobe && !psel)[*8]
		|=> $stable(atten_word);
	endproperty
	a_ser: assert property (p_ser) else $error("serial hold");
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err;
		acc && (paddr > 12'h00C || paddr[1:0] != 2'b00) |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_ok;
		acc && paddr <= 12'h00C && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("false error");
	property p_rd;
		acc && !pwrite && paddr == 12'h008 |-> prdata[6:0] ==
		$past(atten_word) && prdata[11:9] ==
		{strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
	endproperty
	a_rd: assert property (p_rd) else $error("status read");
endmodule
bind sac_top sac_props u_props (.*);

// ### sac_host.sv
// sac_host.sv: host model driving the serial link
`timescale 1ns/1ps
module sac_host (
	// serial link
	output logic serial_clk,
	output logic serial_data
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
	end
	// clock stands low outside frames
	task automatic tick();
		#6 serial_clk = 1'b1;
		#6 serial_clk = 1'b0;
	endtask
	task automatic send(input sac_pkg::sac_frame_t f);
		for (int i = 15; i >= 0; i--) begin
			serial_data = f[i];
			tick();
		end
		// released line must not keep the last bit
		serial_data = ~serial_data;
	endtask
endmodule

// ### tb.sv
// tb.sv: self-checking bench for sac_top
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0, rst = 1'b1, mode = 1'b0, stb = 1'b0, pre = 1'b0;
	logic [2:0] strap = 3'h5;
	logic [6:0] w = 7'h00;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, sclk, sdat;
	logic [6:0] atten_word;
	int n_fail = 0, total_checks = 0;
	always #50 ref_clk = ~ref_clk;
	sac_host h (.serial_clk(sclk), .serial_data(sdat));
	sac_top DUT (.ref_clk(ref_clk), .rst(rst), .serial_clk(sclk),
		.serial_data(sdat), .mode_select_pin(mode), .latch_strobe(stb),
		.pwrup_preset_pin(pre), .strap_addr_bit0(strap[0]),
		.strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
		.weight_bit_16db(w[6]), .weight_bit_8db(w[5]),
		.weight_bit_4db(w[4]), .weight_bit_2db(w[3]),
		.weight_bit_1db(w[2]), .weight_bit_half_db(w[1]),
		.weight_bit_quarter_db(w[0]), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.atten_word(atten_word));
	task automatic summarize();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic reset(input logic p);
		rst <= 1'b1;
		pre <= p;
		stb <= 1'b0;
		// link register clears only while its clock runs
		repeat (4) h.tick();
		cyc(8);
		rst <= 1'b0;
		// two link edges carry the release into the link domain
		repeat (2) h.tick();
		cyc(6);
	endtask
	task automatic strobe();
		cyc(7);
		stb <= 1'b1;
		cyc(9);
		stb <= 1'b0;
		cyc(6);
	endtask
	task automatic t_pwr();
		w <= 7'h15;
		reset(1'b0);
		cmp("max", 32'h7F, atten_word);
		reset(1'b1);
		cmp("preset", 32'h15, atten_word);
		$display("t_pwr done");
	endtask
	task automatic t_dir();
		stb <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			w <= (i == 7) ? 7'h7F : 7'h01 << i;
			cyc(7);
			cmp("direct", (i == 7) ? 32'h7F : 32'h01 << i, atten_word);
		end
		stb <= 1'b0;
		cyc(5);
		w <= 7'h33;
		cyc(6);
		cmp("held", 32'h7F, atten_word);
		stb <= 1'b1;
		cyc(6);
		stb <= 1'b0;
		cmp("latched", 32'h33, atten_word);
		$display("t_dir done");
	endtask
	task automatic t_ser();
		mode <= 1'b1;
		w <= 7'h00;
		cyc(4);
		h.send({8'hFD, 8'h8A});
		strobe();
		cmp("serial", 32'h0A, atten_word);
		h.send({8'h04, 8'h11});
		strobe();
		cmp("mismatch", 32'h0A, atten_word);
		$display("t_ser done");
	endtask
	task automatic t_apb();
		apb(1'b0, 12'h008, 32'h0);
		cmp("status", 32'h1B0A, rd);
		apb(1'b0, 12'h00C, 32'h0);
		cmp("frame", 32'h0411, rd);
		apb(1'b0, 12'h010, 32'h0);
		cmp("unmapped", 32'h1, {31'h0, err});
		cmp("unmapped data", 32'h0, rd);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		cmp("ctrl", 32'h1, rd);
		apb(1'b1, 12'h004, 32'h55);
		cyc(2);
		cmp("atten", 32'h55, atten_word);
		apb(1'b0, 12'h004, 32'h0);
		cmp("atten rd", 32'h55, rd);
		h.send({8'h05, 8'h22});
		strobe();
		cmp("frozen", 32'h55, atten_word);
		apb(1'b1, 12'h000, 32'h0);
		strobe();
		cmp("unfrozen", 32'h22, atten_word);
		$display("t_apb done");
	endtask
	initial begin
		t_pwr();
		t_dir();
		t_ser();
		t_apb();
		summarize();
	end
endmodule
